// File: logic/timer_irq_pkg.sv
// Package: register map, field positions and mode codes of the timer
// capture and interrupt flag block.
// Assumes a 32-bit APB slave with byte addresses and one word per register.
package timer_irq_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] MASK_OFS  = 8'h00;
  localparam logic [ADDR_W-1:0] FLAG_OFS  = 8'h04;
  localparam logic [ADDR_W-1:0] CAPLO_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] CAPHI_OFS = 8'h0c;
  localparam logic [ADDR_W-1:0] CTRL_OFS  = 8'h10;

  // Bit positions shared by the mask and flag registers.
  localparam int OVF_BIT  = 0;
  localparam int CMPA_BIT = 1;
  localparam int CMPB_BIT = 2;
  localparam int CMPC_BIT = 3;
  localparam int CAP_BIT  = 5;

  // Implemented bits; bits 7, 6 and 4 are reserved and read zero.
  localparam logic [7:0] IMPL_BITS  = 8'h2f;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Control register fields.
  localparam int CTRL_EDGE_BIT  = 0;
  localparam int CTRL_ACSEL_BIT = 1;

  // Waveform modes with the capture register as TOP: bit 3 set, bit 0 clear.
  localparam int WGM_TOP_HI_BIT = 3;
  localparam int WGM_TOP_LO_BIT = 0;

  // Interrupt request vector order.
  localparam int REQ_OVF  = 0;
  localparam int REQ_CMPA = 1;
  localparam int REQ_CMPB = 2;
  localparam int REQ_CMPC = 3;
  localparam int REQ_CAP  = 4;
  localparam int NUM_REQ  = 5;

  localparam int NUM_CMP = 3;

endpackage : timer_irq_pkg

// File: logic/capture_edge.sv
// Capture edge detector: one-cycle pulse on the selected edge.
// Assumes the pin level is already synchronous to clk.
`timescale 1ns/1ns
module capture_edge
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pinLevel,
  input  wire logic edgeSel,
  output logic      edgeEvt
);

  typedef struct packed
  {
    logic primed;
    logic prev;
    logic evt;
  } edge_state_type;

  edge_state_type s_q;
  edge_state_type s_d;

  // The first sample only primes the history, so no false edge at reset.
  always_comb
  begin
    s_d        = s_q;
    s_d.primed = 1'b1;
    s_d.prev   = pinLevel;
    s_d.evt    = s_q.primed &&
                 (edgeSel ? (pinLevel && !s_q.prev)
                          : (!pinLevel && s_q.prev));
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign edgeEvt = s_q.evt;

endmodule : capture_edge

// File: logic/flag_bank.sv
// Sticky flag bank: hardware sets, software or vector acknowledge clears.
// Assumes set and clear requests are one-cycle pulses on clk.
`timescale 1ns/1ns
module flag_bank
#(
  parameter int         W     = 8,
  parameter logic [7:0] VALID = 8'h2f
)
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] setEvt,
  input  wire logic [W-1:0] clrReq,
  output logic      [W-1:0] flags
);

  typedef struct packed
  {
    logic [W-1:0] flag;
  } flag_state_type;

  flag_state_type s_q;
  flag_state_type s_d;

  // A set in the same cycle as a clear wins, so no event is lost.
  always_comb
  begin
    s_d = s_q;
    for (int i = 0; i < W; i++)
    begin
      if (!VALID[i])
        s_d.flag[i] = 1'b0;
      else if (setEvt[i])
        s_d.flag[i] = 1'b1;
      else if (clrReq[i])
        s_d.flag[i] = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign flags = s_q.flag;

endmodule : flag_bank

// File: logic/timer_capture_irq_flags.sv
// Capture register, interrupt mask and event flags of one 16-bit timer.
// Assumes the counter unit supplies its value, match, overflow and TOP
// pulses on clk, with timerTick marking each timer clock cycle.
`timescale 1ns/1ns

module timer_capture_irq_flags
#(
  parameter bit HAS_COMPARATOR = 1'b1
)
(
  input  wire logic                             clk,
  input  wire logic                             rst,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [timer_irq_pkg::ADDR_W-1:0] paddr,
  input  wire logic [timer_irq_pkg::DATA_W-1:0] pwdata,
  output logic      [timer_irq_pkg::DATA_W-1:0] prdata,
  output logic                                  pready,
  output logic                                  pslverr,
  input  wire logic [15:0]                      counterValue,
  input  wire logic                             timerTick,
  input  wire logic [2:0]                       cmpMatch,
  input  wire logic [2:0]                       forceCmpStrobe,
  input  wire logic                             overflowEvt,
  input  wire logic                             topReached,
  input  wire logic [3:0]                       waveformModeSel,
  input  wire logic                             capturePin,
  input  wire logic                             comparatorOut,
  input  wire logic                             globalIrqEn,
  input  wire logic [timer_irq_pkg::NUM_REQ-1:0] vectorAck,
  output logic      [15:0]                      captureRegister,
  output logic      [timer_irq_pkg::NUM_REQ-1:0] irqReq,
  output logic                                  irq
);
  import timer_irq_pkg::*;

  typedef struct packed
  {
    logic                pready;
    logic                pslverr;
    logic [DATA_W-1:0]   prdata;
    logic [7:0]          mask;
    logic                edgeSel;
    logic                acSel;
    logic [7:0]          temp;
    logic [15:0]         cap;
    logic [NUM_CMP-1:0]  cmpPend;
    logic [NUM_REQ-1:0]  irqReq;
    logic                irq;
  } top_state_type;

  top_state_type s_q;
  top_state_type s_d;

  logic       captureTop;
  logic       captureSrc;
  logic       edgeEvt;
  logic       pinEvt;
  logic       accessDone;
  logic       wrFlags;
  logic [7:0] flags;
  logic [7:0] setVec;
  logic [7:0] clrVec;
  logic [7:0] ackVec;

  // Modes 8, 10, 12 and 14 take TOP from the capture register.
  assign captureTop = waveformModeSel[WGM_TOP_HI_BIT] &&
                      !waveformModeSel[WGM_TOP_LO_BIT];
  assign captureSrc = (HAS_COMPARATOR && s_q.acSel) ? comparatorOut
                                                   : capturePin;
  assign pinEvt     = edgeEvt && !captureTop;
  assign accessDone = psel && penable && s_q.pready;
  assign wrFlags    = accessDone && pwrite && (paddr == FLAG_OFS);

  capture_edge u_edge
  (
    .clk      (clk),
    .rst      (rst),
    .pinLevel (captureSrc),
    .edgeSel  (s_q.edgeSel),
    .edgeEvt  (edgeEvt)
  );

  always_comb
  begin
    setVec           = RESET_BYTE;
    setVec[OVF_BIT]  = overflowEvt;
    setVec[CMPA_BIT] = timerTick && s_q.cmpPend[0];
    setVec[CMPB_BIT] = timerTick && s_q.cmpPend[1];
    setVec[CMPC_BIT] = timerTick && s_q.cmpPend[2];
    setVec[CAP_BIT]  = captureTop ? topReached
                                  : pinEvt;
    ackVec           = RESET_BYTE;
    ackVec[OVF_BIT]  = vectorAck[REQ_OVF];
    ackVec[CMPA_BIT] = vectorAck[REQ_CMPA];
    ackVec[CMPB_BIT] = vectorAck[REQ_CMPB];
    ackVec[CMPC_BIT] = vectorAck[REQ_CMPC];
    ackVec[CAP_BIT]  = vectorAck[REQ_CAP];
    // Only ones in the written byte clear; zeros leave flags alone.
    clrVec = ackVec | (wrFlags ? pwdata[7:0] : RESET_BYTE);
  end

  flag_bank
  #(
    .W     (8),
    .VALID (IMPL_BITS)
  )
  u_flags
  (
    .clk    (clk),
    .rst    (rst),
    .setEvt (setVec),
    .clrReq (clrVec),
    .flags  (flags)
  );

  always_comb
  begin
    s_d = s_q;

    // One wait state: pready rises in the second access cycle.
    s_d.pready  = psel && penable && !s_q.pready;
    s_d.pslverr = 1'b0;
    if (psel && penable && !s_q.pready)
    begin
      s_d.prdata = '0;
      case (paddr)
        MASK_OFS:  s_d.prdata[7:0] = s_q.mask;
        FLAG_OFS:  s_d.prdata[7:0] = flags;
        CAPLO_OFS: s_d.prdata[7:0] = s_q.cap[7:0];
        CAPHI_OFS: s_d.prdata[7:0] = s_q.temp;
        CTRL_OFS:
        begin
          s_d.prdata[CTRL_EDGE_BIT]  = s_q.edgeSel;
          s_d.prdata[CTRL_ACSEL_BIT] = s_q.acSel;
        end
        default:   s_d.pslverr = 1'b1;
      endcase
    end

    if (accessDone && !pwrite && paddr == CAPLO_OFS)
      s_d.temp = s_q.cap[15:8];

    if (accessDone && pwrite)
    begin
      case (paddr)
        MASK_OFS:  s_d.mask = pwdata[7:0] & IMPL_BITS;
        CAPHI_OFS: s_d.temp = pwdata[7:0];
        // Software sets a TOP value; high byte comes from the latch.
        CAPLO_OFS: s_d.cap  = {s_q.temp, pwdata[7:0]};
        CTRL_OFS:
        begin
          s_d.edgeSel = pwdata[CTRL_EDGE_BIT];
          s_d.acSel   = HAS_COMPARATOR && pwdata[CTRL_ACSEL_BIT];
        end
        default:   s_d.mask = s_q.mask;
      endcase
    end

    // A hardware capture wins over a software write in the same cycle.
    if (pinEvt)
      s_d.cap = counterValue;

    if (timerTick)
      s_d.cmpPend = cmpMatch & ~forceCmpStrobe;

    s_d.irqReq[REQ_OVF]  = globalIrqEn && s_q.mask[OVF_BIT]  &&
                           flags[OVF_BIT];
    s_d.irqReq[REQ_CMPA] = globalIrqEn && s_q.mask[CMPA_BIT] &&
                           flags[CMPA_BIT];
    s_d.irqReq[REQ_CMPB] = globalIrqEn && s_q.mask[CMPB_BIT] &&
                           flags[CMPB_BIT];
    s_d.irqReq[REQ_CMPC] = globalIrqEn && s_q.mask[CMPC_BIT] &&
                           flags[CMPC_BIT];
    s_d.irqReq[REQ_CAP]  = globalIrqEn && s_q.mask[CAP_BIT]  &&
                           flags[CAP_BIT];
    s_d.irq = |(s_q.mask & flags) && globalIrqEn;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign prdata          = s_q.prdata;
  assign pready          = s_q.pready;
  assign pslverr         = s_q.pslverr;
  assign captureRegister = s_q.cap;
  assign irqReq          = s_q.irqReq;
  assign irq             = s_q.irq;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Capture path: pin or comparator events, the shared high-byte latch
  // and the TOP use of the capture register.
  a_capture_copy: assert property (
    pinEvt |=> s_q.cap == $past(counterValue))
    else $error("capture register missed the counter value");

  a_pin_flag: assert property (
    pinEvt |=> flags[CAP_BIT])
    else $error("capture event did not set the capture flag");

  a_temp_latch: assert property (
    accessDone && !pwrite && paddr == CAPLO_OFS
    |=> s_q.temp == $past(s_q.cap[15:8]))
    else $error("temp latch did not take the capture high byte");

  a_temp_write: assert property (
    accessDone && pwrite && paddr == CAPHI_OFS
    |=> s_q.temp == $past(pwdata[7:0]))
    else $error("temp latch did not take the written high byte");

  a_top_write: assert property (
    accessDone && pwrite && paddr == CAPLO_OFS && !pinEvt
    |=> s_q.cap == {$past(s_q.temp), $past(pwdata[7:0])})
    else $error("capture register write lost a byte");

  a_top_blocks_pin: assert property (
    captureTop && edgeEvt && !topReached
    |=> !flags[CAP_BIT] || $past(flags[CAP_BIT]))
    else $error("capture pin acted in capture-TOP mode");

  a_top_holds_cap: assert property (
    captureTop && !(accessDone && pwrite) |=> s_q.cap == $past(s_q.cap))
    else $error("capture register moved in capture-TOP mode");

  a_top_capflag: assert property (
    captureTop && topReached |=> flags[CAP_BIT])
    else $error("capture flag not set at TOP");

  // Mask, request gating and the reserved bits.
  a_mask_write: assert property (
    accessDone && pwrite && paddr == MASK_OFS
    |=> s_q.mask[CAP_BIT] == $past(pwdata[CAP_BIT])
        && s_q.mask[OVF_BIT] == $past(pwdata[OVF_BIT]))
    else $error("mask write did not land on its bit");

  a_reserved_zero: assert property (
    (s_q.mask & ~IMPL_BITS) == 8'h00
    && (flags & ~IMPL_BITS) == 8'h00)
    else $error("reserved mask or flag bit is set");

  a_global_gate: assert property (
    !globalIrqEn |=> !irq && irqReq == '0)
    else $error("interrupt raised with global enable low");

  a_mask_gate: assert property (
    !s_q.mask[CAP_BIT] |=> !irqReq[REQ_CAP])
    else $error("capture request raised while masked");

  a_irq_level: assert property (
    globalIrqEn && (s_q.mask & flags) != 8'h00 |=> irq)
    else $error("unmasked flag did not raise the interrupt");

  // Compare flags: a match is armed at one tick and flagged at the next,
  // so the check is split in two steps instead of counting idle cycles.
  a_cmp_arm: assert property (
    timerTick && cmpMatch[0] && !forceCmpStrobe[0] |=> s_q.cmpPend[0])
    else $error("compare A match was not armed");

  a_cmp_delay: assert property (
    timerTick && s_q.cmpPend[0] |=> flags[CMPA_BIT])
    else $error("compare A flag not set a timer cycle after match");

  a_cmpb_delay: assert property (
    timerTick && s_q.cmpPend[1] |=> flags[CMPB_BIT])
    else $error("compare B flag not set a timer cycle after match");

  a_cmpc_delay: assert property (
    timerTick && s_q.cmpPend[2] |=> flags[CMPC_BIT])
    else $error("compare C flag not set a timer cycle after match");

  a_force_noset: assert property (
    timerTick && forceCmpStrobe[1] |=> !s_q.cmpPend[1])
    else $error("forced compare armed the compare flag");

  a_force_a_noset: assert property (
    timerTick && forceCmpStrobe[0] |=> !s_q.cmpPend[0])
    else $error("forced compare armed the compare A flag");

  a_force_c_noset: assert property (
    timerTick && forceCmpStrobe[2] |=> !s_q.cmpPend[2])
    else $error("forced compare armed the compare C flag");

  // Overflow setting and the clearing paths of the flag register.
  a_ovf_flag: assert property (
    overflowEvt |=> flags[OVF_BIT])
    else $error("overflow event did not set the overflow flag");

  a_w1c_clear: assert property (
    wrFlags && pwdata[OVF_BIT] && !overflowEvt
    |=> !flags[OVF_BIT])
    else $error("write one did not clear the overflow flag");

  a_zero_write: assert property (
    wrFlags && pwdata[7:0] == 8'h00 && ackVec == 8'h00
    |=> (flags & $past(flags)) == $past(flags))
    else $error("writing zero cleared a flag");

  a_vector_clear: assert property (
    vectorAck[REQ_CAP] && !setVec[CAP_BIT] |=> !flags[CAP_BIT])
    else $error("vector acknowledge did not clear the capture flag");

  a_ovf_vector_clear: assert property (
    vectorAck[REQ_OVF] && !overflowEvt |=> !flags[OVF_BIT])
    else $error("vector acknowledge did not clear the overflow flag");

  a_set_wins: assert property (
    overflowEvt && clrVec[OVF_BIT] |=> flags[OVF_BIT])
    else $error("clear beat a simultaneous set");

  // The request follows the flag by one cycle, so a capture shows on
  // irqReq two cycles after the edge pulse.
  c_pin_capture: cover property (pinEvt ##2 s_q.irqReq[REQ_CAP]);
  c_cmp_irq: cover property (setVec[CMPB_BIT] ##[1:3] irq);
  c_top_mode: cover property (captureTop && topReached);
  c_cap_read: cover property (
    accessDone && !pwrite && paddr == CAPHI_OFS);
  c_vector_ack: cover property (vectorAck[REQ_CAP] ##1 !flags[CAP_BIT]);

endmodule : timer_capture_irq_flags

// File: tb/cpu_irq_model.sv
// CPU interrupt side: runs the vector of the lowest pending request.
// Assumes irqReq is registered on clk, as the block drives it.
`timescale 1ns/1ns
module cpu_irq_model
(
  input  wire logic                                clk,
  input  wire logic                                rst,
  input  wire logic                                ackOn,
  input  wire logic [timer_irq_pkg::NUM_REQ-1:0]   irqReq,
  output logic      [timer_irq_pkg::NUM_REQ-1:0]   vectorAck
);
  import timer_irq_pkg::*;
  logic [1:0] holdQ;
  // Backing off three cycles lets flag and request fall first, so one
  // event never gets its vector run twice.
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      vectorAck <= '0;
      holdQ     <= 2'h0;
    end
    else if (holdQ != 2'h0)
    begin
      vectorAck <= '0;
      holdQ     <= holdQ - 2'h1;
    end
    else if (ackOn && irqReq != '0)
    begin
      vectorAck <= irqReq & (~irqReq + 5'h1);
      holdQ     <= 2'h3;
    end
endmodule : cpu_irq_model

// File: tb/tb.sv
// Self-checking bench of the timer capture and interrupt flag block.
// Assumes the APB slave answers within 20 cycles.
`timescale 1ns/1ns
module tb;
  import timer_irq_pkg::*;
  typedef struct {
    int         src;
    logic [7:0] flag;
    logic [4:0] req;
  } row_type;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic        timerTick, overflowEvt, topReached, capturePin;
  logic        globalIrqEn, irq, ackOn, comparatorOut;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [15:0] counterValue, captureRegister;
  logic [2:0]  cmpMatch, forceCmpStrobe;
  logic [3:0]  waveformModeSel;
  logic [4:0]  vectorAck, irqReq;
  int          nMismatch, checksDone;
  row_type     rows [5];

  timer_capture_irq_flags u_timer_capture_irq_flags (.clk, .rst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .counterValue, .timerTick, .cmpMatch, .forceCmpStrobe, .overflowEvt,
    .topReached, .waveformModeSel, .capturePin, .comparatorOut,
    .globalIrqEn, .vectorAck, .captureRegister, .irqReq, .irq);
  cpu_irq_model u_cpu_irq_model (.clk, .rst, .ackOn, .irqReq, .vectorAck);

  initial
  begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checksDone++;
    if (g !== e)
    begin
      nMismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'h1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'h1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1)
    begin
      nMismatch++;
      conclude;
    end
    rdat = prdata;
    err  = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk("prdata", e, rdat);
  endtask : rd

  task automatic tick(input logic [2:0] m, input logic [2:0] f);
    cmpMatch       <= m;
    forceCmpStrobe <= f;
    timerTick      <= 1'h1;
    @(posedge clk);
    cmpMatch       <= 3'h0;
    forceCmpStrobe <= 3'h0;
    timerTick      <= 1'h0;
    @(posedge clk);
  endtask : tick

  task automatic fire(input int k);
    if (k == 0)
      overflowEvt <= 1'h1;
    else if (k == 5)
      topReached <= 1'h1;
    else if (k < 4)
      tick(3'(1 << (k - 1)), 3'h0);
    else
      capturePin <= 1'h0;
    @(posedge clk);
    overflowEvt <= 1'h0;
    topReached  <= 1'h0;
    if (k > 0 && k < 4)
      tick(3'h0, 3'h0);
    @(posedge clk);
    capturePin <= 1'h1;
    repeat (3) @(posedge clk);
  endtask : fire

  initial
  begin
    {rst, psel, penable, pwrite, paddr, pwdata} = '0;
    {timerTick, overflowEvt, topReached, globalIrqEn, ackOn} = '0;
    {cmpMatch, forceCmpStrobe, waveformModeSel} = '0;
    rst = 1'h1;
    capturePin = 1'h1;
    comparatorOut = 1'h1;
    counterValue = 16'h1234;
    rows = '{'{0, 8'h01, 5'h01}, '{1, 8'h02, 5'h02},
             '{2, 8'h04, 5'h04}, '{3, 8'h08, 5'h08},
             '{4, 8'h20, 5'h10}};
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    rd(MASK_OFS, 32'h0);
    rd(FLAG_OFS, 32'h0);
    apb(1'h1, MASK_OFS, 32'hff);
    rd(MASK_OFS, 32'h2f);
    apb(1'h0, 8'h14, 32'h0);
    chk("pslverr", 32'h1, {31'h0, err});
    globalIrqEn <= 1'h1;
    $display("test registers done");
    foreach (rows[i])
    begin
      fire(rows[i].src);
      chk("irqReq", {27'h0, rows[i].req}, {27'h0, irqReq});
      chk("irq", 32'h1, {31'h0, irq});
      rd(FLAG_OFS, {24'h0, rows[i].flag});
      apb(1'h1, FLAG_OFS, {24'h0, rows[i].flag});
      rd(FLAG_OFS, 32'h0);
    end
    $display("test events done");
    chk("capture", 32'h1234, {16'h0, captureRegister});
    rd(CAPLO_OFS, 32'h34);
    counterValue <= 16'h5678;
    fire(4);
    rd(CAPHI_OFS, 32'h12);
    chk("capture", 32'h5678, {16'h0, captureRegister});
    apb(1'h1, FLAG_OFS, 32'h20);
    apb(1'h1, CTRL_OFS, 32'h1);
    counterValue <= 16'h9abc;
    capturePin <= 1'h0;
    repeat (3) @(posedge clk);
    rd(FLAG_OFS, 32'h0);
    capturePin <= 1'h1;
    repeat (3) @(posedge clk);
    chk("capture", 32'h9abc, {16'h0, captureRegister});
    apb(1'h1, FLAG_OFS, 32'h20);
    apb(1'h1, CTRL_OFS, 32'h2);
    rd(CTRL_OFS, 32'h2);
    counterValue <= 16'h0f0e;
    comparatorOut <= 1'h0;
    repeat (3) @(posedge clk);
    chk("capture", 32'h0f0e, {16'h0, captureRegister});
    rd(FLAG_OFS, 32'h20);
    apb(1'h1, FLAG_OFS, 32'h20);
    comparatorOut <= 1'h1;
    apb(1'h1, CTRL_OFS, 32'h0);
    $display("test capture done");
    waveformModeSel <= 4'hc;
    fire(4);
    rd(FLAG_OFS, 32'h0);
    fire(5);
    rd(FLAG_OFS, 32'h20);
    apb(1'h1, FLAG_OFS, 32'h20);
    apb(1'h1, CAPHI_OFS, 32'h44);
    apb(1'h1, CAPLO_OFS, 32'h55);
    chk("capture", 32'h4455, {16'h0, captureRegister});
    waveformModeSel <= 4'h0;
    tick(3'h7, 3'h7);
    tick(3'h0, 3'h0);
    rd(FLAG_OFS, 32'h0);
    $display("test top and force done");
    globalIrqEn <= 1'h0;
    fire(0);
    chk("irq", 32'h0, {31'h0, irq});
    globalIrqEn <= 1'h1;
    repeat (3) @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'h1, MASK_OFS, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'h1, FLAG_OFS, 32'h0);
    rd(FLAG_OFS, 32'h1);
    fire(4);
    apb(1'h1, MASK_OFS, 32'h2f);
    ackOn <= 1'h1;
    repeat (8) @(posedge clk);
    rd(FLAG_OFS, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    ackOn <= 1'h0;
    fork
      apb(1'h1, FLAG_OFS, 32'h1);
      begin
        repeat (2) @(posedge clk);
        overflowEvt <= 1'h1;
        @(posedge clk);
        overflowEvt <= 1'h0;
      end
    join
    rd(FLAG_OFS, 32'h1);
    apb(1'h1, FLAG_OFS, 32'h1);
    rd(FLAG_OFS, 32'h0);
    $display("test interrupt done");
    conclude;
  end
endmodule : tb
